// ==== octl_pkg.sv ====
// Shared constants for the single-shot timer enable control block
package octl_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_CH    = 11;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned DATA_W    = 32;

  // ****************************************************************
  // Enable control registers: printed offsets are register indexes,
  // the byte address on the bus is four times the index
  // ****************************************************************
  localparam logic [ADDR_W-1:0] IDX_EXT_PERMIT  = 32'h0080_02fa;
  localparam logic [ADDR_W-1:0] IDX_WR_PROTECT  = 32'h0080_02fc;
  localparam logic [ADDR_W-1:0] IDX_CNT_ENABLE  = 32'h0080_02fe;
  localparam logic [REG_W-1:0]  RST_EXT_PERMIT  = 16'h0000;
  localparam logic [REG_W-1:0]  RST_WR_PROTECT  = 16'h0000;
  localparam logic [REG_W-1:0]  RST_CNT_ENABLE  = 16'h0000;

  // Channel c sits at bit CH0_BIT - c; bits below CH10_BIT are unused
  localparam int unsigned CH0_BIT  = 15;
  localparam int unsigned CH10_BIT = 5;

  // ****************************************************************
  // Per-channel window: reload, correction, counter (read only)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CH_BASE      = 32'h0000_0100;
  localparam logic [ADDR_W-1:0] CH_STRIDE    = 32'h0000_0010;
  localparam logic [3:0]        OFS_RELOAD   = 4'h0;
  localparam logic [3:0]        OFS_CORRECT  = 4'h4;
  localparam logic [3:0]        OFS_COUNTER  = 4'h8;
  localparam logic [CNT_W-1:0]  RST_COUNTER  = 16'h0000;
  localparam logic [CNT_W-1:0]  RST_RELOAD   = 16'h0000;
  localparam logic [CNT_W-1:0]  RST_CORRECT  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_UNDER    = 16'hffff;

endpackage

// ==== octl_channel.sv ====
// One single-shot down-counter channel with correction adder
`timescale 1ns/1ns
module octl_channel
  import octl_pkg::*;
(
  input  wire logic             core_clk,       // System clock
  input  wire logic             rst_b,          // Async reset, active low
  input  wire logic             count_tick,     // Prescaled count clock strobe
  input  wire logic             start,          // Load reload value this tick
  input  wire logic             enable,         // Count enable bit
  input  wire logic             reload_we,      // Reload register write strobe
  input  wire logic             correct_we,     // Correction register write strobe
  input  wire logic [CNT_W-1:0] wdata,          // Write data
  output logic      [CNT_W-1:0] reload_value,   // Reload register
  output logic      [CNT_W-1:0] correct_value,  // Correction register
  output logic      [CNT_W-1:0] counter_value,  // Counter
  output logic                  running,        // Counter active
  output logic                  underflow_now,  // Underflow on this edge
  output logic                  out_level,      // Output flip-flop
  output logic                  underflow_irq   // Underflow event pulse
);

  // ****************************************************************
  // Internal state
  // ****************************************************************
  logic corr_pend_r;
  logic do_correct;

  // Underflow only when counting normally; a correction period never underflows
  assign do_correct    = count_tick && running && enable && !start && corr_pend_r;
  assign underflow_now = count_tick && running && enable && !start && !corr_pend_r &&
                         (counter_value == '0);  // [RULE8]

  // Software-visible reload and correction values
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_value  <= RST_RELOAD;
      correct_value <= RST_CORRECT;
    end else begin
      if (reload_we) begin
        reload_value <= wdata;
      end
      if (correct_we) begin
        correct_value <= wdata;
      end
    end
  end

  // Correction waits for the next count period; a new write wins over its consumption
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      corr_pend_r <= 1'b0;
    end else if (correct_we) begin
      corr_pend_r <= 1'b1;  // [RULE14]
    end else if (count_tick && (start || do_correct)) begin
      corr_pend_r <= 1'b0;
    end
  end

  // Counter: load on start, add correction instead of decrementing, halt on wrap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_value <= RST_COUNTER;
      running       <= 1'b0;
    end else if (count_tick) begin
      if (start) begin
        counter_value <= reload_value;  // [RULE8] [RULE12]
        running       <= 1'b1;
      end else if (!enable) begin
        running <= 1'b0;  // [RULE4]
      end else if (do_correct) begin
        // Decrement skipped, so the run grows by correction + 1; carry is dropped
        counter_value <= counter_value + correct_value;  // [RULE13] [RULE15] [RULE16]
      end else if (underflow_now) begin
        counter_value <= CNT_UNDER;
        running       <= 1'b0;  // [RULE8]
      end else if (running) begin
        counter_value <= counter_value - 16'h0001;
      end
    end
  end

  // Output toggles at start and at underflow; events only move on a count tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_level     <= 1'b0;
      underflow_irq <= 1'b0;
    end else begin
      underflow_irq <= underflow_now;  // [RULE10] [RULE16]
      if (count_tick && (start || underflow_now)) begin
        out_level <= !out_level;  // [RULE9] [RULE11]
      end
    end
  end

endmodule

// ==== octl_timer.sv ====
// Enable control and single-shot timing for eleven output counter channels
//
// Functional notes
// RULE1: External enable only honoured when permit bit set
// RULE2: Protect bit set blocks count-enable rewrite
// RULE3: Host clears protect, then writes enable one
// RULE4: Host clears protect, writes zero; counting stops
// RULE5: Underflow halt clears count-enable bit automatically
// RULE6: Host uses halfword accesses for enable registers; this APB port takes 32-bit words, the register in bits 15:0
// RULE7: Start by software write or external enable
// RULE8: Enable loads reload, count down, halt underflow
// RULE9: Output toggles at start and underflow
// RULE10: Underflow raises an interrupt request event
// RULE11: First output change waits for count tick
// RULE12: Prior counter contents ignored; reload always loaded
// RULE13: Correction value added to running counter
// RULE14: Correction applied in following count period
// RULE15: Correction period skips decrement, adds one more
// RULE16: Correction overflow raises no interrupt itself
// RULE17: Underflow halt beats same-period external enable
// RULE18: Software enable write beats underflow, external enable
// RULE19: Unused low bits read zero, ignore writes
`timescale 1ns/1ns
module octl_timer
  import octl_pkg::*;
(
  input  wire logic                       core_clk,       // 20 MHz system clock
  input  wire logic                       rst_b,          // Async reset, active low
  input  wire logic                       count_tick,     // Prescaler strobe, same domain
  input  wire logic [octl_pkg::NUM_CH-1:0] ext_enable,    // External enable pins
  input  wire logic                       psel,           // APB select
  input  wire logic                       penable,        // APB enable
  input  wire logic                       pwrite,         // APB direction
  input  wire logic [octl_pkg::ADDR_W-1:0] paddr,         // APB byte address
  input  wire logic [octl_pkg::DATA_W-1:0] pwdata,        // APB write data
  output logic      [octl_pkg::DATA_W-1:0] prdata,        // APB read data
  output logic                            pready,         // APB ready
  output logic                            pslverr,        // APB error
  output logic      [octl_pkg::NUM_CH-1:0] timer_out,     // Output flip-flops
  output logic      [octl_pkg::NUM_CH-1:0] underflow_irq  // Underflow event pulses
);

  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [2:0] {
    SEL_NONE, SEL_PERMIT, SEL_PROTECT, SEL_ENABLE, SEL_RELOAD, SEL_CORRECT, SEL_COUNTER
  } octl_sel_t;

  // Channel flags packed into register image
  function automatic logic [REG_W-1:0] pack_bits(input logic [NUM_CH-1:0] v);
    logic [REG_W-1:0] r;
    r = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      r[CH0_BIT - c] = v[c];
    end
    return r;  // [RULE19]
  endfunction

  // Register image unpacked to channel flags; low bits fall away
  function automatic logic [NUM_CH-1:0] unpack_bits(input logic [REG_W-1:0] r);
    logic [NUM_CH-1:0] v;
    v = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      v[c] = r[CH0_BIT - c];
    end
    return v;  // [RULE1] [RULE19]
  endfunction

  // Byte address of an enable register from its index
  function automatic logic [ADDR_W-1:0] idx_addr(input logic [ADDR_W-1:0] idx);
    return {idx[ADDR_W-3:0], 2'b00};
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [NUM_CH-1:0] permit_r;
  logic [NUM_CH-1:0] protect_r;
  logic [NUM_CH-1:0] cen_r;
  logic [NUM_CH-1:0] start_pend_r;
  logic [NUM_CH-1:0] sw_touch_r;
  logic [NUM_CH-1:0] ext_pend_r;
  logic [NUM_CH-1:0] ext_meta_r;
  logic [NUM_CH-1:0] ext_sync_r;
  logic [NUM_CH-1:0] ext_prev_r;
  logic [NUM_CH-1:0] ext_rise;
  logic [NUM_CH-1:0] ext_go;
  logic [NUM_CH-1:0] start;
  logic [NUM_CH-1:0] running;
  logic [NUM_CH-1:0] uf_now;
  logic [NUM_CH-1:0] reload_we;
  logic [NUM_CH-1:0] correct_we;
  logic [NUM_CH-1:0] sw_we;
  logic [NUM_CH-1:0] sw_val;
  logic [CNT_W-1:0]  reload_v  [NUM_CH];
  logic [CNT_W-1:0]  correct_v [NUM_CH];
  logic [CNT_W-1:0]  counter_v [NUM_CH];
  octl_sel_t         sel;
  logic [3:0]        sel_ch;
  logic              wr_acc;
  logic [DATA_W-1:0] rd_nxt;

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // Map address to register and channel; anything else is unmapped
  always_comb begin
    logic [ADDR_W-1:0] rel;
    rel    = paddr - CH_BASE;
    sel    = SEL_NONE;
    sel_ch = '0;
    if (paddr == idx_addr(IDX_EXT_PERMIT)) begin
      sel = SEL_PERMIT;
    end else if (paddr == idx_addr(IDX_WR_PROTECT)) begin
      sel = SEL_PROTECT;
    end else if (paddr == idx_addr(IDX_CNT_ENABLE)) begin
      sel = SEL_ENABLE;
    end else if (paddr >= CH_BASE && rel < CH_STRIDE * NUM_CH) begin
      sel_ch = rel[7:4];
      unique case (rel[3:0])
        OFS_RELOAD:  sel = SEL_RELOAD;
        OFS_CORRECT: sel = SEL_CORRECT;
        OFS_COUNTER: sel = SEL_COUNTER;
        default:     sel = SEL_NONE;
      endcase
    end
  end

  // Zero-wait slave; error only for unmapped addresses or counter writes
  assign pready  = 1'b1;
  assign pslverr = psel && penable &&
                   ((sel == SEL_NONE) || (pwrite && (sel == SEL_COUNTER)));
  assign wr_acc  = psel && penable && pwrite && !pslverr;

  // Per-channel write strobes
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      reload_we[c]  = wr_acc && (sel == SEL_RELOAD) && (sel_ch == 4'(c));
      correct_we[c] = wr_acc && (sel == SEL_CORRECT) && (sel_ch == 4'(c));
    end
  end

  // Enable bits software may change: protected ones are left alone
  assign sw_we  = (wr_acc && (sel == SEL_ENABLE)) ? ~protect_r : '0;  // [RULE2] [RULE3]
  assign sw_val = unpack_bits(pwdata[REG_W-1:0]);

  // Read mux; data captured in setup so it is stable through access
  always_comb begin
    rd_nxt = '0;
    unique case (sel)
      SEL_PERMIT:  rd_nxt[REG_W-1:0] = pack_bits(permit_r);
      SEL_PROTECT: rd_nxt[REG_W-1:0] = pack_bits(protect_r);
      SEL_ENABLE:  rd_nxt[REG_W-1:0] = pack_bits(cen_r);  // [RULE5]
      SEL_RELOAD:  rd_nxt[CNT_W-1:0] = reload_v[sel_ch];
      SEL_CORRECT: rd_nxt[CNT_W-1:0] = correct_v[sel_ch];
      SEL_COUNTER: rd_nxt[CNT_W-1:0] = counter_v[sel_ch];
      SEL_NONE:    rd_nxt = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // ****************************************************************
  // Permit and protect registers
  // ****************************************************************

  // Plain storage; unassigned low bits are never stored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      permit_r  <= unpack_bits(RST_EXT_PERMIT);
      protect_r <= unpack_bits(RST_WR_PROTECT);
    end else if (wr_acc) begin
      if (sel == SEL_PERMIT) begin
        permit_r <= sw_val;  // [RULE19]
      end
      if (sel == SEL_PROTECT) begin
        protect_r <= sw_val;
      end
    end
  end

  // ****************************************************************
  // External enable inputs
  // ****************************************************************

  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_meta_r <= '0;
      ext_sync_r <= '0;
      ext_prev_r <= '0;
    end else begin
      ext_meta_r <= ext_enable;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  assign ext_rise = ext_sync_r & ~ext_prev_r;

  // Rising edge held until the next count tick; a new edge wins over the clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_pend_r <= '0;
    end else if (count_tick) begin
      ext_pend_r <= ext_rise;
    end else begin
      ext_pend_r <= ext_pend_r | ext_rise;
    end
  end

  // External start only for idle, permitted channels untouched by software
  assign ext_go = ext_pend_r & permit_r & ~cen_r & ~sw_touch_r;  // [RULE1] [RULE7] [RULE18]

  // ****************************************************************
  // Count enable and start control
  // ****************************************************************

  // Software activity in the current count period, for priority at the tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_touch_r <= '0;
    end else if (count_tick) begin
      sw_touch_r <= sw_we;
    end else begin
      sw_touch_r <= sw_touch_r | sw_we;
    end
  end

  // Start request: loads reload on the next count tick, never earlier
  assign start = count_tick ? ((start_pend_r & cen_r) | ext_go) : '0;  // [RULE11]

  // Pending start from software 0 to 1, or a software-kept restart after underflow
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_pend_r <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (sw_we[c] && sw_val[c] && !cen_r[c]) begin
          start_pend_r[c] <= 1'b1;  // [RULE3] [RULE7]
        end else if (uf_now[c] && cen_r[c] && (sw_touch_r[c] || (sw_we[c] && sw_val[c]))) begin
          start_pend_r[c] <= 1'b1;  // [RULE18]
        end else if (count_tick || !cen_r[c]) begin
          start_pend_r[c] <= 1'b0;
        end
      end
    end
  end

  // Enable bit: software write wins, then underflow halt, then external start
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cen_r <= unpack_bits(RST_CNT_ENABLE);
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (sw_we[c]) begin
          cen_r[c] <= sw_val[c];  // [RULE2] [RULE4] [RULE18]
        end else if (uf_now[c] && !sw_touch_r[c]) begin
          cen_r[c] <= 1'b0;  // [RULE5] [RULE17]
        end else if (ext_go[c] && count_tick) begin
          cen_r[c] <= 1'b1;  // [RULE7]
        end
      end
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************

  // One counter per channel; enable is the control bit ORed with the external start
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    octl_channel u_ch (
      .core_clk      (core_clk),
      .rst_b         (rst_b),
      .count_tick    (count_tick),
      .start         (start[g]),
      .enable        (cen_r[g] | ext_go[g]),
      .reload_we     (reload_we[g]),
      .correct_we    (correct_we[g]),
      .wdata         (pwdata[CNT_W-1:0]),
      .reload_value  (reload_v[g]),
      .correct_value (correct_v[g]),
      .counter_value (counter_v[g]),
      .running       (running[g]),
      .underflow_now (uf_now[g]),
      .out_level     (timer_out[g]),
      .underflow_irq (underflow_irq[g])
    );
  end

endmodule

// ==== octl_timer_asserts.sv ====
// Port-level checker for the single-shot timer enable control block
`timescale 1ns/1ns
module octl_timer_asserts
  import octl_pkg::*;
(
  input wire logic                        core_clk,       // Clock
  input wire logic                        rst_b,          // Reset, active low
  input wire logic                        count_tick,     // Count strobe
  input wire logic [octl_pkg::NUM_CH-1:0] ext_enable,     // External enables
  input wire logic                        psel,           // APB select
  input wire logic                        penable,        // APB enable
  input wire logic                        pwrite,         // APB direction
  input wire logic [octl_pkg::ADDR_W-1:0] paddr,          // APB address
  input wire logic [octl_pkg::DATA_W-1:0] pwdata,         // APB write data
  input wire logic [octl_pkg::DATA_W-1:0] prdata,         // APB read data
  input wire logic                        pready,         // APB ready
  input wire logic                        pslverr,        // APB error
  input wire logic [octl_pkg::NUM_CH-1:0] timer_out,      // Output flip-flops
  input wire logic [octl_pkg::NUM_CH-1:0] underflow_irq   // Underflow pulses
);
  // ****************************************************************
  // Decodes
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Access phase and the three enable register byte addresses
  logic acc;
  logic en_reg;
  assign acc    = psel && penable;
  assign en_reg = paddr == (IDX_EXT_PERMIT << 2) || paddr == (IDX_WR_PROTECT << 2) ||
                  paddr == (IDX_CNT_ENABLE << 2);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_ready; acc |-> pready; endproperty
  property p_err_acc; pslverr |-> acc; endproperty
  property p_err_low;
    acc && !pwrite && paddr < CH_BASE && !en_reg |-> pslverr && prdata == '0;
  endproperty
  property p_err_cnt; acc && pwrite && paddr == CH_BASE + OFS_COUNTER |-> pslverr; endproperty
  property p_en_low;
    acc && !pwrite && en_reg |-> !pslverr && prdata[31:16] == '0 && prdata[4:0] == '0;
  endproperty
  property p_out_tick; $changed(timer_out) |-> $past(count_tick); endproperty
  property p_out_hold; !count_tick |=> $stable(timer_out); endproperty
  property p_irq_pulse; |underflow_irq |=> (underflow_irq & $past(underflow_irq)) == '0; endproperty
  property p_irq_out;
    (underflow_irq & ~((timer_out ^ $past(timer_out)) | ($past(timer_out) ^ $past(timer_out, 2))
      | ($past(timer_out, 2) ^ $past(timer_out, 3)))) == '0;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");
  a_err_low: assert property (p_err_low) else $error("unmapped access not refused");
  a_err_cnt: assert property (p_err_cnt) else $error("counter write not refused");
  a_en_low: assert property (p_en_low) else $error("unused enable bits not zero");
  a_out_tick: assert property (p_out_tick) else $error("output moved off tick");
  a_out_hold: assert property (p_out_hold) else $error("output moved without tick");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
  a_irq_out: assert property (p_irq_out) else $error("irq without output edge");
  // Main scenarios seen
  c_irq: cover property (|underflow_irq);
  c_err: cover property (pslverr);
  c_out: cover property ($rose(timer_out[0]));
endmodule

bind octl_timer octl_timer_asserts u_asserts (.*);

// ==== octl_pins.sv ====
// Far-side model: count clock strobe source and external enable pins
`timescale 1ns/1ns
module octl_pins
  import octl_pkg::*;
#(
  parameter int TICK_DIV = 6
)(
  input  wire logic                        core_clk,    // Clock
  input  wire logic                        rst_b,       // Reset, active low
  input  wire logic [octl_pkg::NUM_CH-1:0] ext_req,     // Bench asks for an event
  output logic                             count_tick,  // Prescaled strobe
  output logic      [octl_pkg::NUM_CH-1:0] ext_enable   // External enable pins
);
  int div_r;
  int hold_r [NUM_CH];
  // ****************************************************************
  // Prescaler strobe, one cycle in TICK_DIV; spacing keeps toggles apart
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r      <= 0;
      count_tick <= 1'b0;
    end else begin
      div_r      <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
      count_tick <= (div_r == TICK_DIV - 1);
    end
  end
  // Pin held high four cycles so the two-stage synchroniser sees the edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_b) hold_r[c] <= 0;
      else hold_r[c] <= ext_req[c] ? 4 : (hold_r[c] > 0 ? hold_r[c] - 1 : 0);
      ext_enable[c] <= rst_b && (ext_req[c] || hold_r[c] > 1);
    end
  end
endmodule

// ==== oneshot_timer_enable_ctl_tb.sv ====
// Self-checking bench for the single-shot timer enable control block
`timescale 1ns/1ns
module oneshot_timer_enable_ctl_tb;
  import octl_pkg::*;
  localparam logic [31:0] A_PERM = IDX_EXT_PERMIT << 2;
  localparam logic [31:0] A_PROT = IDX_WR_PROTECT << 2;
  localparam logic [31:0] A_CEN  = IDX_CNT_ENABLE << 2;
  logic              core_clk, rst_b, psel, penable, pwrite, pready, pslverr, count_tick, err;
  logic [31:0]       paddr, pwdata, prdata, rd;
  logic [NUM_CH-1:0] ext_req, ext_enable, timer_out, underflow_irq;
  int                fail_count, n_checks, cycles;
  int                hi_ticks [NUM_CH];
  int                irqs [NUM_CH];
  // ****************************************************************
  // Clock, reset, partner, design
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  octl_pins #(.TICK_DIV(6)) u_pins (.core_clk(core_clk), .rst_b(rst_b), .ext_req(ext_req),
    .count_tick(count_tick), .ext_enable(ext_enable));
  octl_timer uut (.core_clk(core_clk), .rst_b(rst_b), .count_tick(count_tick),
    .ext_enable(ext_enable), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_out(timer_out), .underflow_irq(underflow_irq));
  // Monitor: ticks seen while a pulse is high, underflow events, hang limit
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    for (int c = 0; c < NUM_CH; c++) begin
      if (count_tick && timer_out[c]) hi_ticks[c] <= hi_ticks[c] + 1;
      if (underflow_irq[c]) irqs[c] <= irqs[c] + 1;
    end
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n * 6) @(posedge core_clk);
  endtask
  // Arm channel c with a reload value and clear its counters
  task automatic arm(input int c, input logic [15:0] rl);
    apb(1'b1, CH_BASE + CH_STRIDE * c + OFS_RELOAD, {16'h0000, rl});
    hi_ticks[c] = 0;
    irqs[c] = 0;
  endtask
  // Wait for channel c's pulse to finish
  task automatic wait_done(input int c);
    for (int i = 0; i < 2000 && !(timer_out[c] === 1'b0 && hi_ticks[c] > 0); i++)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask
  // Wait until channel c has counted n high ticks
  task automatic until_hi(input int c, input int n);
    for (int i = 0; i < 200 && hi_ticks[c] < n; i++) @(posedge core_clk);
  endtask
  task automatic ext_pulse(input logic [NUM_CH-1:0] m);
    @(posedge core_clk) ext_req <= m;
    @(posedge core_clk) ext_req <= '0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] regs [3] = '{A_PERM, A_PROT, A_CEN};
    foreach (regs[i]) begin
      apb(1'b0, regs[i], '0);
      check(rd, 32'h0000_0000);
    end
    apb(1'b0, 32'h0000_0010, '0);
    check(err, 1'b1);
    check(rd, '0);
    apb(1'b1, CH_BASE + OFS_COUNTER, 32'h0000_1234);
    check(err, 1'b1);
    apb(1'b1, A_PERM, 32'hffff_ffff);
    apb(1'b0, A_PERM, '0);
    check(rd, 32'h0000_ffe0);
    apb(1'b1, A_PERM, '0);
  endtask
  task automatic t_protect_shot();
    arm(0, 16'h0002);
    apb(1'b1, A_PROT, 32'h0000_8000);
    apb(1'b1, A_CEN, 32'h0000_8000);
    apb(1'b0, A_CEN, '0);
    check(rd, 32'h0000_0000);
    apb(1'b1, A_PROT, '0);
    apb(1'b1, A_CEN, 32'h0000_8000);
    apb(1'b0, A_CEN, '0);
    check(rd, 32'h0000_8000);
    wait_done(0);
    check(hi_ticks[0], 3);
    check(irqs[0], 1);
    apb(1'b0, A_CEN, '0);
    check(rd, 32'h0000_0000);
    arm(0, 16'h0005);
    apb(1'b1, A_CEN, 32'h0000_8000);
    wait_done(0);
    check(hi_ticks[0], 6);
  endtask
  task automatic t_ext();
    arm(3, 16'h0001);
    ext_pulse(11'h008);
    ticks(3);
    check(timer_out[3], 1'b0);
    apb(1'b1, A_PERM, 32'h0000_1000);
    ext_pulse(11'h008);
    wait_done(3);
    check(hi_ticks[3], 2);
  endtask
  task automatic t_correct();
    arm(5, 16'h0007);
    apb(1'b1, A_CEN, 32'h0000_0400);
    until_hi(5, 4);
    apb(1'b1, CH_BASE + CH_STRIDE * 5 + OFS_CORRECT, 32'h0000_0003);
    wait_done(5);
    check(hi_ticks[5], 12);
    check(irqs[5], 1);
  endtask
  task automatic t_stop();
    logic [31:0] first;
    arm(1, 16'h0100);
    apb(1'b1, A_CEN, 32'h0000_4000);
    ticks(3);
    apb(1'b1, A_CEN, 32'h0000_0000);
    apb(1'b0, A_CEN, '0);
    check(rd, 32'h0000_0000);
    ticks(1);
    apb(1'b0, CH_BASE + CH_STRIDE + OFS_COUNTER, '0);
    first = rd;
    ticks(3);
    apb(1'b0, CH_BASE + CH_STRIDE + OFS_COUNTER, '0);
    check(rd, first);
    check(irqs[1], 0);
  endtask
  // Enable rewrite in the underflow period restarts; an edge then is dropped
  task automatic t_race();
    arm(3, 16'h0003);
    apb(1'b1, A_CEN, 32'h0000_1000);
    until_hi(3, 3);
    apb(1'b1, A_CEN, 32'h0000_1000);
    until_hi(3, 6);
    ext_pulse(11'h008);
    ticks(4);
    wait_done(3);
    check(hi_ticks[3], 8);
    check(irqs[3], 2);
  endtask
  // Main sequence: reset held two cycles, then each scenario
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; ext_req = '0;
    fail_count = 0; n_checks = 0; cycles = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_protect_shot();
    t_ext();
    t_correct();
    t_stop();
    t_race();
    print_verdict();
  end
endmodule
